/* design/sbs_tap.sv */
// Boundary scan test access port with bypass, ID and pin ring registers.
`timescale 1ns/1ps
`include "sbs_map.svh"

module sbs_tap #(
	parameter logic [31:0] ID_WORD = `SBS_ID_DEFAULT
) (
	// Core clock and power-up reset.
	input wire logic core_clk,
	input wire logic reset,
	// Test port pins.
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe,
	// Pin ring, unconnected-pin cells included.
	input wire logic [68:0] pin_ring,
	// Status toward the memory core, in core clock domain.
	output logic outputs_off,
	output logic tap_in_reset
);
	import sbs_pkg::*;

	sbs_state_t state;
	sbs_state_t next_state;
	logic in_rst;
	logic next_in_rst;
	logic off_req;
	logic next_off_req;

	sbs_instr_t ir;
	sbs_instr_t next_ir;
	logic [`SBS_IR_W-1:0] ir_sr;
	logic [`SBS_IR_W-1:0] next_ir_sr;

	logic bypass;
	logic next_bypass;
	logic [`SBS_ID_W-1:0] id_sr;
	logic [`SBS_ID_W-1:0] next_id_sr;
	logic [`SBS_BSR_W-1:0] bsr;
	logic [`SBS_BSR_W-1:0] next_bsr;

	logic [`SBS_BSR_W-1:0] ring_m;
	logic [`SBS_BSR_W-1:0] ring_s;

	logic next_tdo;
	logic next_tdo_oe;
	logic [1:0] core_m;
	logic [1:0] core_s;

	logic sel_id;
	logic sel_bsr;
	logic sel_byp;
	logic in_shift;

	// Controller state machine.
	always_comb begin
		next_state = state;
		case (state)
			S_TLR: next_state = tms ? S_TLR : S_RTI;
			S_RTI: next_state = tms ? S_SELDR : S_RTI;
			S_SELDR: next_state = tms ? S_SELIR : S_CAPDR;
			S_CAPDR: next_state = tms ? S_EX1DR : S_SHDR;
			S_SHDR: next_state = tms ? S_EX1DR : S_SHDR;
			S_EX1DR: next_state = tms ? S_UPDR : S_PDR;
			S_PDR: next_state = tms ? S_EX2DR : S_PDR;
			S_EX2DR: next_state = tms ? S_UPDR : S_SHDR;
			S_UPDR: next_state = tms ? S_SELDR : S_RTI;
			S_SELIR: next_state = tms ? S_TLR : S_CAPIR;
			S_CAPIR: next_state = tms ? S_EX1IR : S_SHIR;
			S_SHIR: next_state = tms ? S_EX1IR : S_SHIR;
			S_EX1IR: next_state = tms ? S_UPIR : S_PIR;
			S_PIR: next_state = tms ? S_EX2IR : S_PIR;
			S_EX2IR: next_state = tms ? S_UPIR : S_SHIR;
			S_UPIR: next_state = tms ? S_SELDR : S_RTI;
			default: next_state = S_TLR;
		endcase
		// Decoded from next values so the crossings see glitch-free flops.
		next_in_rst = (next_state == S_TLR);
		next_off_req = (next_ir == `SBS_IR_SAMPLEZ);
	end

	always_ff @(posedge tck or posedge reset) begin
		if (reset) begin
			state <= S_TLR;
			in_rst <= `SBS_FLAG_SET;
			off_req <= `SBS_FLAG_CLR;
		end else begin
			state <= next_state;
			in_rst <= next_in_rst;
			off_req <= next_off_req;
		end
	end

	// Instruction register: shifter plus held instruction.
	always_comb begin
		next_ir = ir;
		next_ir_sr = ir_sr;
		case (state)
			S_TLR: next_ir = `SBS_IR_IDCODE;
			S_CAPIR: next_ir_sr = `SBS_IR_CAPTURE;
			S_SHIR: next_ir_sr = {tdi, ir_sr[`SBS_IR_W-1:1]};
			S_UPIR: next_ir = ir_sr;
			default: next_ir = ir;
		endcase
	end

	always_ff @(posedge tck or posedge reset) begin
		if (reset) begin
			ir <= `SBS_IR_IDCODE;
			ir_sr <= `SBS_IR_CAPTURE;
		end else begin
			ir <= next_ir;
			ir_sr <= next_ir_sr;
		end
	end

	// Register selection. Reserved codes fall back to bypass so a stray
	// code still leaves a sane one-bit path.
	always_comb begin
		sel_id = (ir == `SBS_IR_IDCODE);
		sel_bsr = (ir == `SBS_IR_EXTEST) ||
			(ir == `SBS_IR_SAMPLEZ) ||
			(ir == `SBS_IR_SAMPLE);
		sel_byp = !sel_id && !sel_bsr;
		in_shift = (state == S_SHDR) || (state == S_SHIR);
	end

	// Pin ring synchroniser; the ring runs on unrelated memory clocks.
	always_ff @(posedge tck or posedge reset) begin
		if (reset) begin
			ring_m <= `SBS_BSR_RST;
			ring_s <= `SBS_BSR_RST;
		end else begin
			ring_m <= pin_ring;
			ring_s <= ring_m;
		end
	end

	// Data registers. Update-DR falls to the default and touches nothing:
	// there is no preload stage and no path into the memory.
	always_comb begin
		next_bypass = bypass;
		next_id_sr = id_sr;
		next_bsr = bsr;
		case (state)
			S_CAPDR: begin
				if (sel_bsr) begin
					next_bsr = ring_s;
				end
				if (sel_id) begin
					next_id_sr = ID_WORD;
				end
				if (sel_byp) begin
					next_bypass = `SBS_BYPASS_CLR;
				end
			end
			S_SHDR: begin
				if (sel_bsr) begin
					next_bsr = {tdi, bsr[`SBS_BSR_W-1:1]};
				end
				if (sel_id) begin
					next_id_sr = {tdi, id_sr[`SBS_ID_W-1:1]};
				end
				if (sel_byp) begin
					next_bypass = tdi;
				end
			end
			default: next_bsr = bsr;
		endcase
	end

	always_ff @(posedge tck or posedge reset) begin
		if (reset) begin
			bypass <= `SBS_BYPASS_CLR;
			id_sr <= `SBS_ID_RST;
			bsr <= `SBS_BSR_RST;
		end else begin
			bypass <= next_bypass;
			id_sr <= next_id_sr;
			bsr <= next_bsr;
		end
	end

	// Serial output, launched on the falling edge for half a cycle of hold.
	always_comb begin
		next_tdo = tdo;
		next_tdo_oe = in_shift;
		if (state == S_SHIR) begin
			next_tdo = ir_sr[0];
		end else if (state == S_SHDR) begin
			if (sel_id) begin
				next_tdo = id_sr[0];
			end else if (sel_bsr) begin
				next_tdo = bsr[0];
			end else begin
				next_tdo = bypass;
			end
		end
	end

	always_ff @(negedge tck or posedge reset) begin
		if (reset) begin
			tdo <= `SBS_FLAG_CLR;
			tdo_oe <= `SBS_FLAG_CLR;
		end else begin
			tdo <= next_tdo;
			tdo_oe <= next_tdo_oe;
		end
	end

	// Status into the core clock domain. The test clock may stop at any
	// time, so only levels cross, each through two flops.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			core_m <= `SBS_CORE_RST;
			core_s <= `SBS_CORE_RST;
		end else begin
			core_m <= {off_req, in_rst};
			core_s <= core_m;
		end
	end

	always_comb begin
		outputs_off = core_s[1];
		tap_in_reset = core_s[0];
	end

	// Checks on the test clock.
	tlr_five_a: assert property (
		@(posedge tck) disable iff (reset)
		tms [*5] |=> state == S_TLR)
		else $error("five high mode bits did not reset the controller");

	ir_reset_a: assert property (
		@(posedge tck) disable iff (reset)
		state == S_TLR |=> ir == `SBS_IR_IDCODE)
		else $error("reset state did not load identification code");

	ir_capture_a: assert property (
		@(posedge tck) disable iff (reset)
		state == S_CAPIR |=> ir_sr[1:0] == 2'h1)
		else $error("capture pattern 01 missing in instruction shifter");

	ir_update_a: assert property (
		@(posedge tck) disable iff (reset)
		state == S_SHIR ##1 state == S_SHIR |-> $stable(ir))
		else $error("instruction changed before update");

	ir_take_a: assert property (
		@(posedge tck) disable iff (reset)
		state == S_UPIR |=> ir == $past(ir_sr))
		else $error("update did not take shifted instruction");

	bypass_clear_a: assert property (
		@(posedge tck) disable iff (reset)
		state == S_CAPDR && ir == `SBS_IR_BYPASS
		|=> bypass == `SBS_BYPASS_CLR)
		else $error("bypass bit not cleared on capture");

	id_capture_a: assert property (
		@(posedge tck) disable iff (reset)
		state == S_CAPDR && ir == `SBS_IR_IDCODE |=> id_sr == ID_WORD)
		else $error("identification word not captured");

	bsr_capture_a: assert property (
		@(posedge tck) disable iff (reset)
		state == S_CAPDR && (ir == `SBS_IR_SAMPLE || ir == `SBS_IR_EXTEST)
		|=> bsr == $past(ring_s))
		else $error("pin ring not captured");

	bsr_shift_a: assert property (
		@(posedge tck) disable iff (reset)
		state == S_SHDR && ir == `SBS_IR_SAMPLEZ
		|=> bsr[`SBS_BSR_W-1] == $past(tdi) &&
		bsr[`SBS_BSR_W-2:0] == $past(bsr[`SBS_BSR_W-1:1]))
		else $error("pin chain did not shift from serial input");

	update_dr_a: assert property (
		@(posedge tck) disable iff (reset)
		state == S_UPDR |=> $stable(bsr) && $stable(ir))
		else $error("update under sample changed state");

	tdo_hiz_a: assert property (
		@(negedge tck) disable iff (reset)
		1'h1 |=> tdo_oe == $past(in_shift))
		else $error("serial output enable wrong outside shift states");

endmodule : sbs_tap

/* design/sbs_map.svh */
// Constants for the boundary scan test port: codes, widths and layouts.
`ifndef SBS_MAP_SVH
`define SBS_MAP_SVH

// Register widths.
`define SBS_IR_W 3
`define SBS_ID_W 32
`define SBS_BSR_W 69

// Instruction codes.
`define SBS_IR_EXTEST 3'h0
`define SBS_IR_IDCODE 3'h1
`define SBS_IR_SAMPLEZ 3'h2
`define SBS_IR_RSVD3 3'h3
`define SBS_IR_SAMPLE 3'h4
`define SBS_IR_RSVD5 3'h5
`define SBS_IR_RSVD6 3'h6
`define SBS_IR_BYPASS 3'h7

// Value loaded into the instruction shifter in Capture-IR (low bits 01).
`define SBS_IR_CAPTURE 3'h1

// Identification word; the value is arbitrary, bit 0 marks presence.
`define SBS_ID_DEFAULT 32'h1234_5679

// Reset and clear values.
`define SBS_BYPASS_CLR 1'h0
`define SBS_BSR_RST 69'h0
`define SBS_ID_RST 32'h0
`define SBS_FLAG_SET 1'h1
`define SBS_FLAG_CLR 1'h0
// Core-side status after reset: controller in reset, outputs not off.
`define SBS_CORE_RST 2'h1

`endif

/* design/sbs_pkg.sv */
// Types shared by the boundary scan test port.
package sbs_pkg;
	typedef logic [2:0] sbs_instr_t;
	typedef enum logic [3:0] {
		S_TLR, S_RTI,
		S_SELDR, S_CAPDR, S_SHDR, S_EX1DR, S_PDR, S_EX2DR, S_UPDR,
		S_SELIR, S_CAPIR, S_SHIR, S_EX1IR, S_PIR, S_EX2IR, S_UPIR
	} sbs_state_t;
endpackage : sbs_pkg

/* bench/sbs_ctl.sv */
// Model of the external scan controller that drives the test port.
`timescale 1ns/1ps

module sbs_ctl (
	// Test port pins.
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo,
	input wire logic tdo_oe
);
	logic oe_seen;

	// The test clock stands low between frames.
	initial begin
		tck = 1'h0;
		tms = 1'h1;
		tdi = 1'h1;
		oe_seen = 1'h0;
	end

	// One 160 ns test clock; pins move only while the clock is low.
	task step(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#80;
		q = tdo;
		oe_seen = tdo_oe;
		tck = 1'h1;
		#80;
		tck = 1'h0;
	endtask : step

	// Mode select held high for five rises resets the controller.
	task tlr();
		logic q;
		repeat (5) step(1'h1, 1'h0, q);
	endtask : tlr

	// Scan n bits, least significant first, from and back to idle.
	task scan(input logic ir, input int n, input logic [68:0] din,
		output logic [68:0] dout, output logic oe_ok);
		logic q;
		dout = 69'h0;
		oe_ok = 1'h1;
		step(1'h1, 1'h0, q);
		if (ir) step(1'h1, 1'h0, q);
		step(1'h0, 1'h0, q);
		step(1'h0, 1'h0, q);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], q);
			dout[i] = q;
			oe_ok &= oe_seen;
		end
		step(1'h1, 1'h0, q);
		oe_ok &= !oe_seen;
		step(1'h0, 1'h0, q);
	endtask : scan
endmodule : sbs_ctl

/* bench/tb_top.sv */
// Self-checking testbench for the boundary scan test port.
`timescale 1ns/1ps
`include "sbs_map.svh"

module tb_top;
	import sbs_pkg::*;
	// Arbitrary identification value; only bit 0 has a meaning.
	localparam logic [31:0] ID_T = 32'hA5C3_0F01;
	logic core_clk, reset, tck, tms, tdi, tdo, tdo_oe;
	logic outputs_off, tap_in_reset, oe_ok, q;
	logic [68:0] pin_ring, pins, din, dout;
	logic [31:0] seed;
	sbs_instr_t codes [3];
	int fail_count, checks_done, cycles;

	sbs_tap #(.ID_WORD(ID_T)) u_sbs_tap (.core_clk(core_clk),
		.reset(reset), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
		.tdo_oe(tdo_oe), .pin_ring(pin_ring), .outputs_off(outputs_off),
		.tap_in_reset(tap_in_reset));
	sbs_ctl u_sbs_ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
		.tdo_oe(tdo_oe));

	initial begin
		core_clk = 1'h0;
		forever #2 core_clk = ~core_clk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task draw(output logic [68:0] v);
		for (int i = 0; i < 69; i++) begin
			seed = lfsr(seed);
			v[i] = seed[0];
		end
	endtask : draw

	task cmp_vec(input string what, input logic [68:0] exp,
		input logic [68:0] got);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp_vec

	task cmp_bit(input string what, input logic exp, input logic got);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s expected %b seen %b", what, exp, got);
		end
	endtask : cmp_bit

	task results();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : results

	// A hang ends the run well past the expected length of the tests.
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			fail_count++;
			results();
		end
	end

	initial begin
		reset = 1'h1;
		pin_ring = 69'h0;
		seed = 32'h28;
		fail_count = 0;
		checks_done = 0;
		cycles = 0;
		codes = '{`SBS_IR_EXTEST, `SBS_IR_SAMPLEZ, `SBS_IR_SAMPLE};
		repeat (20) @(posedge core_clk);
		@(negedge core_clk);
		reset = 1'h0;
		cmp_bit("in reset", 1'h1, tap_in_reset);
		cmp_bit("oe idle", 1'h0, tdo_oe);
		// Leave Test-Logic-Reset first; scans start from Run-Test/Idle.
		u_sbs_ctl.step(1'h0, 1'h0, q);
		u_sbs_ctl.scan(1'h0, 32, 69'h0, dout, oe_ok);
		cmp_vec("id word", {37'h0, ID_T}, dout);
		cmp_bit("out of reset", 1'h0, tap_in_reset);
		cmp_bit("dr oe", 1'h1, oe_ok);
		u_sbs_ctl.scan(1'h1, 3, 69'h1, dout, oe_ok);
		cmp_vec("ir capture", 69'h1, dout);
		cmp_bit("ir oe", 1'h1, oe_ok);
		$display("test id done");
		foreach (codes[k]) begin
			draw(pins);
			if (k == 0) pins = {69{1'h1}};
			@(negedge core_clk) pin_ring = pins;
			u_sbs_ctl.scan(1'h1, 3, {66'h0, codes[k]}, dout, oe_ok);
			cmp_bit("outputs off", codes[k] == 3'h2, outputs_off);
			draw(din);
			u_sbs_ctl.scan(1'h0, 69, din, dout, oe_ok);
			cmp_vec("ring", pins, dout);
			u_sbs_ctl.scan(1'h0, 69, ~din, dout, oe_ok);
			cmp_vec("ring again", pins, dout);
			$display("test code %b done", codes[k]);
		end
		u_sbs_ctl.scan(1'h1, 3, 69'h7, dout, oe_ok);
		draw(din);
		u_sbs_ctl.scan(1'h0, 8, din, dout, oe_ok);
		cmp_vec("bypass", {61'h0, din[6:0], 1'h0}, dout);
		cmp_bit("outputs off", 1'h0, outputs_off);
		$display("test bypass done");
		u_sbs_ctl.tlr();
		repeat (10) @(negedge core_clk);
		cmp_bit("in reset", 1'h1, tap_in_reset);
		u_sbs_ctl.step(1'h0, 1'h0, q);
		u_sbs_ctl.scan(1'h0, 32, 69'h0, dout, oe_ok);
		cmp_vec("id after reset", {37'h0, ID_T}, dout);
		$display("test reset done");
		results();
	end
endmodule : tb_top
